/* File: flash_host.sv */
// Host controller for a parallel flash: command writes, status polling,
// hardware reset and deep power-down, ordered through a register port.
// Assumes the flash pins (ready/busy and data) are asynchronous to MCLK.
`timescale 1ns/1ps
module flash_host
   import flash_host_pkg::*;
#(
   parameter logic [31:0] PROG_LIMIT  = BUF_CYC,
   parameter logic [31:0] ERASE_LIMIT = ERASE_CYC,
   parameter logic [31:0] RELEASE_CYC = RDP_CYC
) (
   input  wire logic        MCLK,
   input  wire logic        RESETN,
   input  wire logic [7:0]  REG_ADDR_IN,
   input  wire logic [31:0] REG_WDATA_IN,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA_OUT,
   output logic      [23:0] FL_ADDR,
   output logic      [15:0] DQ_O,
   input  wire logic [15:0] DQ_I,
   output logic             DQ_OE_N,
   output logic             CE_N,
   output logic             OE_N,
   output logic             WE_N,
   output logic             RESET_N,
   output logic             ACC,
   input  wire logic        READY_BUSY_N
);

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [15:0] dq_s1, dq_s2;
   logic        rb_s1, rb_s2;

   // Data and ready/busy cross from the flash into MCLK
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
      end else begin
         dq_s1 <= DQ_I;
         dq_s2 <= dq_s1;
         rb_s1 <= READY_BUSY_N;
         rb_s2 <= rb_s1;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   state_t      state;
   op_t         op_r;
   logic [23:0] addr_r;
   logic [15:0] wdata_r;
   logic [15:0] rd_cur, rd_prev;
   logic        done, fail, fail_set;
   logic        start;
   op_t         req_op;

   assign req_op = op_t'(REG_WDATA_IN[2:0]);
   // New operation codes are ignored while an operation is in flight; the ACC bit still updates
   assign start = REG_WR && (REG_ADDR_IN == REG_CTRL) &&
                  (req_op != OP_NONE) && (req_op <= OP_RDP) &&
                  (state == S_IDLE);

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         addr_r  <= 24'h000000;
         wdata_r <= 16'h0000;
         ACC     <= 1'b0;
      end else if (REG_WR) begin
         if (REG_ADDR_IN == REG_ADDR)
            addr_r <= REG_WDATA_IN[23:0];
         if (REG_ADDR_IN == REG_WDATA)
            wdata_r <= REG_WDATA_IN[15:0];
         if (REG_ADDR_IN == REG_CTRL)
            ACC <= REG_WDATA_IN[CTRL_ACC];
      end
   end

   // Sticky result flags; a start clears them, completion sets done and loads fail with the verdict.
   // Set on the edge that leaves the finish state, so done rises as busy
   // drops and the verdict latched in the evaluation state is not lost.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         done <= 1'b0;
         fail <= 1'b0;
      end else if (state == S_FINISH) begin
         done <= 1'b1;
         fail <= fail_set;
      end else if (start) begin
         done <= 1'b0;
         fail <= 1'b0;
      end
   end

   // Read data valid the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         REG_RDATA_OUT <= 32'h00000000;
      else if (REG_RD) begin
         case (REG_ADDR_IN)
            REG_CTRL:   REG_RDATA_OUT <= {23'h0, ACC, 5'h0, op_r};
            REG_ADDR:   REG_RDATA_OUT <= {8'h00, addr_r};
            REG_WDATA:  REG_RDATA_OUT <= {16'h0000, wdata_r};
            REG_STATUS: REG_RDATA_OUT <= {27'h0, ACC, rb_s2, fail, done,
                                          state != S_IDLE};
            REG_RDATA:  REG_RDATA_OUT <= {16'h0000, rd_cur};
            default:    REG_RDATA_OUT <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Command sequences
   // ----------------------------------------------------------------------
   logic [2:0]  step;
   logic [2:0]  last_step;
   logic [39:0] cyc;

   // Address and data of each command cycle, packed {addr, data}
   function automatic logic [39:0] seq(op_t o, logic [2:0] s,
                                       logic [23:0] a, logic [15:0] d);
      logic [39:0] r;
      r = {UNLOCK_A1, UNLOCK_D1};
      if (s == 3'd1 || s == 3'd4)
         r = {UNLOCK_A2, UNLOCK_D2};
      else if (o == OP_PROG && s == 3'd2)
         r = {UNLOCK_A1, CMD_PROG};
      else if (o == OP_PROG && s == 3'd3)
         r = {a, d};
      else if (o == OP_ERASE && s == 3'd2)
         r = {UNLOCK_A1, CMD_ERASE};
      else if (o == OP_ERASE && s == 3'd5)
         r = {a, CMD_SECTOR};
      else if (o == OP_DPD)
         r = {UNLOCK_A1, CMD_DPD};
      else if (o == OP_RDP)
         r = {UNLOCK_A1, CMD_RDP};
      return r;
   endfunction

   assign cyc       = seq(op_r, step, addr_r, wdata_r);
   assign last_step = (op_r == OP_PROG) ? 3'd3 :
                      (op_r == OP_ERASE) ? 3'd5 : 3'd0;

   // ----------------------------------------------------------------------
   // Sequencer and pin drive
   // ----------------------------------------------------------------------
   logic [31:0] tmr, target, elapsed, limit, rd_cnt;
   logic        pidx, recheck, hold_long, toggling, timed_out;

   assign toggling  = rd_cur[BIT_TOGGLE] ^ rd_prev[BIT_TOGGLE];
   // Erase budget covers pre-programming as well as the erase proper
   assign limit     = (op_r == OP_ERASE) ? ERASE_LIMIT : PROG_LIMIT;
   assign timed_out = elapsed >= limit;

   // Overall operation time, checked only at a polling verdict
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         elapsed <= 32'h00000000;
      else if (start)
         elapsed <= 32'h00000000;
      else if (state != S_IDLE && !timed_out)
         elapsed <= elapsed + 32'h00000001;
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state     <= S_IDLE;
         op_r      <= OP_NONE;
         step      <= 3'd0;
         tmr       <= 32'h00000000;
         target    <= 32'h00000000;
         pidx      <= 1'b0;
         recheck   <= 1'b0;
         hold_long <= 1'b0;
         rd_cur    <= 16'h0000;
         rd_prev   <= 16'h0000;
         rd_cnt    <= 32'h00000000;
         fail_set  <= 1'b0;
         FL_ADDR   <= 24'h000000;
         DQ_O      <= 16'h0000;
         DQ_OE_N   <= 1'b1;
         CE_N      <= 1'b1;
         OE_N      <= 1'b1;
         WE_N      <= 1'b1;
         RESET_N   <= 1'b1;
      end else begin
         fail_set <= 1'b0;
         tmr      <= tmr + 32'h00000001;
         case (state)
            S_IDLE: begin
               tmr <= 32'h00000000;
               if (start) begin
                  op_r    <= req_op;
                  step    <= 3'd0;
                  pidx    <= 1'b0;
                  recheck <= 1'b0;
                  rd_cnt  <= 32'h00000000;
                  if (req_op == OP_READ)
                     state <= S_RD_LOW;
                  else if (req_op == OP_RESET) begin
                     // Pulse width depends on whether an algorithm runs
                     hold_long <= !rb_s2;
                     RESET_N   <= 1'b0;
                     state     <= S_RST_LOW;
                  end else
                     state <= S_WR_SET;
               end
            end
            S_WR_SET: begin
               FL_ADDR <= cyc[39:16];
               DQ_O    <= cyc[15:0];
               DQ_OE_N <= 1'b0;
               CE_N    <= 1'b0;
               WE_N    <= 1'b0;
               tmr     <= 32'h00000000;
               state   <= S_WR_LOW;
            end
            S_WR_LOW: if (tmr == WP_CYC - 32'h1) begin
               WE_N  <= 1'b1;
               tmr   <= 32'h00000000;
               state <= S_WR_HIGH;
            end
            S_WR_HIGH: if (tmr == WPH_CYC - 32'h1) begin
               tmr <= 32'h00000000;
               if (step != last_step) begin
                  step  <= step + 3'd1;
                  state <= S_WR_SET;
               end else begin
                  DQ_OE_N <= 1'b1;
                  CE_N    <= 1'b1;
                  if (op_r == OP_DPD) begin
                     target <= DP_CYC;
                     state  <= S_DELAY;
                  end else if (op_r == OP_RDP) begin
                     target <= RELEASE_CYC;
                     state  <= S_DELAY;
                  end else
                     state <= S_RD_LOW;
               end
            end
            S_RD_LOW: begin
               // Poll at the programmed word or inside the erased sector
               FL_ADDR <= addr_r;
               DQ_OE_N <= 1'b1;
               CE_N    <= 1'b0;
               OE_N    <= 1'b0;
               // Two extra cycles cover the data synchroniser
               if (tmr == ACC_CYC + 32'h1) begin
                  rd_prev <= rd_cur;
                  rd_cur  <= dq_s2;
                  rd_cnt  <= rd_cnt + 32'h00000001;
                  CE_N    <= 1'b1;
                  OE_N    <= 1'b1;
                  tmr     <= 32'h00000000;
                  state   <= S_RD_REL;
               end
            end
            S_RD_REL: if (tmr == DF_CYC - 32'h1) begin
               tmr <= 32'h00000000;
               if (op_r == OP_READ)
                  state <= S_FINISH;
               else if (!pidx) begin
                  pidx  <= 1'b1;
                  state <= S_RD_LOW;
               end else
                  state <= S_EVAL;
            end
            S_EVAL: begin
               pidx <= 1'b0;
               tmr  <= 32'h00000000;
               if (!toggling)
                  state <= S_FINISH;
               else if (timed_out) begin
                  fail_set <= 1'b1;
                  state    <= S_FINISH;
               end else if (rd_cur[BIT_TLIMIT]) begin
                  // Both status bits may move together: read once more
                  if (recheck) begin
                     fail_set <= 1'b1;
                     state    <= S_FINISH;
                  end else begin
                     recheck <= 1'b1;
                     state   <= S_RD_LOW;
                  end
               end else
                  state <= S_RD_LOW;
            end
            S_DELAY: if (tmr >= target)
               state <= S_FINISH;
            S_RST_LOW: begin
               if (tmr == (hold_long ? RP1_CYC : RP2_CYC) - 32'h1) begin
                  RESET_N <= 1'b1;
                  state   <= S_RST_WAIT;
               end
            end
            S_RST_WAIT: begin
               // Measured from the reset fall; only the idle case adds the high time before use
               if (rb_s2 && tmr >= (hold_long ? READY1_CYC :
                                    READY2_CYC + RH_CYC))
                  state <= S_FINISH;
            end
            S_FINISH: begin
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [31:0] rst_lo;

   // Length of the current reset pulse, for the pulse-width checks
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN)
         rst_lo <= 32'h00000000;
      else if (!RESET_N)
         rst_lo <= rst_lo + 32'h00000001;
      else
         rst_lo <= 32'h00000000;
   end

   property p_rst_abort;
      $rose(RESET_N) && hold_long |-> rst_lo >= RP1_CYC;
   endproperty
   a_rst_abort: assert property (p_rst_abort)
      else $error("reset pulse too short for a running algorithm");

   property p_rst_idle;
      $rose(RESET_N) |-> rst_lo >= RP2_CYC;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("reset pulse shorter than idle minimum");

   property p_poll_prog_addr;
      !OE_N && op_r == OP_PROG |-> FL_ADDR == addr_r;
   endproperty
   a_poll_prog_addr: assert property (p_poll_prog_addr)
      else $error("program poll read at wrong address");

   property p_poll_erase_sect;
      !OE_N && op_r == OP_ERASE |->
         FL_ADDR[23:SECT_LSB] == addr_r[23:SECT_LSB];
   endproperty
   a_poll_erase_sect: assert property (p_poll_erase_sect)
      else $error("erase poll read outside erased sector");

   sequence s_q5_first;
      state == S_EVAL && toggling && rd_cur[BIT_TLIMIT] &&
         !recheck && !timed_out;
   endsequence
   // The output enable falls one cycle after the read state is entered
   sequence s_reread;
      state == S_RD_LOW && recheck ##1 !OE_N && FL_ADDR == addr_r;
   endsequence
   property p_q5_reread;
      s_q5_first |=> s_reread ##1 !OE_N;
   endproperty
   a_q5_reread: assert property (p_q5_reread)
      else $error("failure path skipped status re-read");

   property p_pair_compare;
      state == S_EVAL |-> rd_cnt >= 32'd2 && rd_cnt[0] == 1'b0;
   endproperty
   a_pair_compare: assert property (p_pair_compare)
      else $error("toggle verdict without two reads");

   property p_further_read;
      state == S_EVAL && recheck |-> rd_cnt >= 32'd4;
   endproperty
   a_further_read: assert property (p_further_read)
      else $error("no further read after time-limit flag");

endmodule

/* File: flash_host_bench.sv */
// Self-checking bench for the flash host controller with a flash model.
// Assumes the package, controller and flash model are compiled first.
`timescale 1ns/1ps
module flash_host_bench
   import flash_host_pkg::*;
;
   logic        MCLK = 1'b0;
   logic        RESETN = 1'b0;
   logic [7:0]  ra = 8'h00;
   logic [31:0] wd = 32'h0;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        hang = 1'b0;
   logic        rb_lo;
   logic [31:0] rdat;
   logic [23:0] fa, cur_a, msk;
   logic [15:0] dq_o, fq, dq;
   logic        oe_d, ce, oe, we, rst, acc, rbn;
   int          fails = 0;
   int          n_tests = 0;
   int          low_n = 0;
   int          cyc = 0;
   int          bad = 0;
   // ----------------------------------------------------------------
   // Clock, bus resolution and pin monitors
   // ----------------------------------------------------------------
   always #5 MCLK = ~MCLK;
   assign dq = oe_d ? fq : dq_o;
   always @(posedge MCLK) cyc <= cyc + 1;
   always @(posedge MCLK) if (!rst) low_n <= low_n + 1;
   always @(posedge MCLK) if (!oe && !rbn && ((fa ^ cur_a) & msk) != 0) bad++;
   flash_host #(.PROG_LIMIT(32'h190), .ERASE_LIMIT(32'h7D0),
      .RELEASE_CYC(32'h32)) uut (
      .MCLK(MCLK), .RESETN(RESETN), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd),
      .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA_OUT(rdat), .FL_ADDR(fa),
      .DQ_O(dq_o), .DQ_I(dq), .DQ_OE_N(oe_d), .CE_N(ce), .OE_N(oe),
      .WE_N(we), .RESET_N(rst), .ACC(acc), .READY_BUSY_N(rbn));
   flash_model flash (.CE_N(ce), .OE_N(oe), .WE_N(we), .RESET_N(rst),
      .HANG(hang), .A(fa), .D(dq), .Q(fq), .RB_N(rbn));
   // Expected status word: acc, ready/busy, fail, done, busy
   function automatic logic [31:0] st(logic a, logic r, logic f);
      return 32'({a, r, f, 2'b10});
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge MCLK);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge MCLK);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge MCLK);
      rd_s <= 1'b0;
      #1;
      d = rdat;
   endtask
   // Start an op, optionally poke a refused op, poll until not busy
   task automatic op(input logic [31:0] c, input logic poke,
                     output logic [31:0] s);
      int i;
      wr(REG_CTRL, c);
      repeat (3) @(posedge MCLK);
      if (poke) wr(REG_CTRL, 32'h5);
      s = 32'h1;
      i = 0;
      while (s[0] !== 1'b0 && i < 6000) begin
         rd(REG_STATUS, s);
         if (s[0] === 1'b1 && s[3] === 1'b0) rb_lo = 1'b1;
         i++;
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #300000;
      fails++;
      end_sim();
   end
   initial begin
      logic [31:0] s, t0;
      logic [23:0] a;
      logic [15:0] d;
      s = $urandom(49);
      repeat (2) @(posedge MCLK);
      RESETN <= 1'b1;
      rd(REG_STATUS, s);
      chk(s, 32'h8);
      rd(8'h14, s);
      chk(s, 32'h0);
      // Random word programs, the last one accelerated
      for (int k = 0; k < 3; k++) begin
         a = 24'($urandom);
         d = 16'($urandom);
         cur_a = a;
         msk = 24'hFFFFFF;
         rb_lo = 1'b0;
         wr(REG_ADDR, 32'(a));
         wr(REG_WDATA, 32'(d));
         op({23'h0, k == 2, 8'h02}, k == 0, s);
         chk(s, st(k == 2, 1'b1, 1'b0));
         chk(32'(rb_lo), 32'h1);
         chk(32'(acc), 32'(k == 2));
         rd(REG_CTRL, s);
         chk(32'(s[2:0]), 32'h2);
         op(32'h1, 1'b0, s);
         rd(REG_RDATA, s);
         chk(s, 32'(d));
      end
      msk = 24'hFF0000;
      op(32'h3, 1'b0, s);
      chk(s, st(0, 1, 0));
      op(32'h1, 1'b0, s);
      rd(REG_RDATA, s);
      chk(s, 32'h0000FFFF);
      // Hung program, then abort by reset, then an idle reset
      hang <= 1'b1;
      msk = 24'hFFFFFF;
      op(32'h2, 1'b0, s);
      chk(s, st(0, 0, 1));
      hang <= 1'b0;
      low_n = 0;
      op(32'h4, 1'b0, s);
      chk(s, st(0, 1, 0));
      chk(32'(low_n >= RP1_CYC), 32'h1);
      low_n = 0;
      op(32'h4, 1'b0, s);
      chk(s, st(0, 1, 0));
      chk(32'(low_n >= RP2_CYC && low_n < RP1_CYC), 32'h1);
      t0 = cyc;
      op(32'h5, 1'b0, s);
      chk(32'(cyc - t0 >= DP_CYC), 32'h1);
      t0 = cyc;
      op(32'h6, 1'b0, s);
      chk(s, st(0, 1, 0));
      chk(32'(cyc - t0 >= 32'h32), 32'h1);
      chk(32'(bad), 32'h0);
      end_sim();
   end
endmodule

/* File: flash_host_pkg.sv */
// Constants shared by the parallel flash host controller.
// Assumes a 100 MHz controller clock and a word-wide flash with 24 address
// bits, driven through its chip, output, write and reset pins.
package flash_host_pkg;

   // ----------------------------------------------------------------------
   // Clock and pin timing (times as printed, cycles derived)
   // ----------------------------------------------------------------------
   localparam int          CLK_NS          = 10;
   localparam int          T_WP_NS         = 35;   // Write strobe low
   localparam int          T_WPH_NS        = 30;   // Write strobe high
   localparam int          T_ACC_NS        = 100;  // Read access
   localparam int          T_DF_NS         = 20;   // Bus release after read
   localparam int          T_RP1_US        = 10;   // Reset pulse, algorithm
   localparam int          T_RP2_NS        = 500;  // Reset pulse, idle
   localparam int          T_RH_NS         = 200;  // Reset high before read
   localparam int          T_READY1_US     = 20;   // Reset recovery, busy
   localparam int          T_READY2_NS     = 500;  // Reset recovery, idle
   localparam int          T_DP_MAX_US     = 20;   // Power-down entry
   localparam int          T_RDP_MAX_US    = 200;  // Power-down release
   localparam int          T_BUF_MAX_US    = 800;  // Buffer program limit
   localparam int          T_ERASE_MAX_MS  = 3500; // Sector erase limit
   localparam int          T_PREPROG_MS    = 3500; // Pre-program allowance

   // Least times round up, waits for a longest time use the exact figure
   localparam logic [31:0] WP_CYC     = 32'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] WPH_CYC    = 32'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] ACC_CYC    = 32'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] DF_CYC     = 32'((T_DF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] RP1_CYC    = 32'(T_RP1_US * 1000 / CLK_NS);
   localparam logic [31:0] RP2_CYC    = 32'((T_RP2_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] RH_CYC     = 32'((T_RH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] READY1_CYC = 32'(T_READY1_US * 1000 / CLK_NS);
   localparam logic [31:0] READY2_CYC = 32'(T_READY2_NS / CLK_NS);
   localparam logic [31:0] DP_CYC     = 32'(T_DP_MAX_US * 1000 / CLK_NS);
   localparam logic [31:0] RDP_CYC    = 32'(T_RDP_MAX_US * 1000 / CLK_NS);
   localparam logic [31:0] BUF_CYC    = 32'(T_BUF_MAX_US * 1000 / CLK_NS);
   localparam logic [31:0] ERASE_CYC  =
      32'((T_ERASE_MAX_MS + T_PREPROG_MS) * 100000);

   // ----------------------------------------------------------------------
   // Software register map and fields
   // ----------------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_ADDR    = 8'h04;
   localparam logic [7:0]  REG_WDATA   = 8'h08;
   localparam logic [7:0]  REG_STATUS  = 8'h0C;
   localparam logic [7:0]  REG_RDATA   = 8'h10;
   localparam int          CTRL_ACC    = 8;
   localparam int          ST_BUSY     = 0;
   localparam int          ST_DONE     = 1;
   localparam int          ST_FAIL     = 2;
   localparam int          ST_RB       = 3;
   localparam int          ST_ACC      = 4;
   localparam int          SECT_LSB    = 16;   // 64K-word sectors

   // ----------------------------------------------------------------------
   // Flash status bits and command cycles
   // ----------------------------------------------------------------------
   localparam int          BIT_POLL    = 7;    // complement_poll_bit
   localparam int          BIT_TOGGLE  = 6;    // toggle_status_bit
   localparam int          BIT_TLIMIT  = 5;    // time_limit_flag
   localparam logic [23:0] UNLOCK_A1   = 24'h000555;
   localparam logic [23:0] UNLOCK_A2   = 24'h0002AA;
   localparam logic [15:0] UNLOCK_D1   = 16'h00AA;
   localparam logic [15:0] UNLOCK_D2   = 16'h0055;
   localparam logic [15:0] CMD_PROG    = 16'h00A0;
   localparam logic [15:0] CMD_ERASE   = 16'h0080;
   localparam logic [15:0] CMD_SECTOR  = 16'h0030;
   localparam logic [15:0] CMD_DPD     = 16'h00B9;
   localparam logic [15:0] CMD_RDP     = 16'h00AB;

   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_READ  = 3'h1,
      OP_PROG  = 3'h2,
      OP_ERASE = 3'h3,
      OP_RESET = 3'h4,
      OP_DPD   = 3'h5,
      OP_RDP   = 3'h6
   } op_t;

   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_WR_SET   = 4'h1,
      S_WR_LOW   = 4'h3,
      S_WR_HIGH  = 4'h2,
      S_RD_LOW   = 4'h6,
      S_RD_REL   = 4'h7,
      S_EVAL     = 4'h5,
      S_DELAY    = 4'h4,
      S_RST_LOW  = 4'hC,
      S_RST_WAIT = 4'hD,
      S_FINISH   = 4'hF
   } state_t;

endpackage

/* File: flash_model.sv */
// Behavioural parallel flash facing the host controller in the bench.
// Assumes the bench resolves the shared data bus from the host's data enable alone.
`timescale 1ns/1ps
module flash_model #(
   parameter int T_PROG  = 2000,
   parameter int T_PRE   = 3000,
   parameter int T_ERASE = 5000
) (
   input  wire logic        CE_N,
   input  wire logic        OE_N,
   input  wire logic        WE_N,
   input  wire logic        RESET_N,
   input  wire logic        HANG,
   input  wire logic [23:0] A,
   input  wire logic [15:0] D,
   output logic      [15:0] Q,
   output logic             RB_N
);
   logic [15:0] mem [logic [23:0]];
   logic [15:0] prev = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic        busy = 1'b0;
   logic        tog  = 1'b0;
   int          t;
   // ----------------------------------------------------------------
   // Command cycles, taken as the write strobe rises
   // ----------------------------------------------------------------
   always @(posedge WE_N) begin
      if (!CE_N && RESET_N && !busy) begin
         t = 0;
         if (prev == 16'h00A0) begin
            mem[A] = D;
            t = T_PROG;
         end else if (D == 16'h0030) begin
            foreach (mem[k]) if (k[23:16] == A[23:16]) mem[k] = 16'hFFFF;
            t = T_PRE + T_ERASE;
         end
         prev = D;  // Power-down codes start no busy time and have no modelled effect
         if (t > 0) begin
            busy = 1'b1;
            #(t);
            if (!HANG) busy = 1'b0;  // A hung algorithm waits for reset
         end
      end
   end
   // Status bits on polls, array data when idle
   always @(negedge OE_N) if (busy) tog = ~tog;
   assign RB_N = ~busy;
   always @* begin
      if (!CE_N && !OE_N) begin
         if (busy) Q = {9'h000, tog, HANG, 5'h00};
         else Q = mem.exists(A) ? mem[A] : 16'hFFFF;
         last = Q;
      end else Q = ~last;  // No pull-up, so a stale value must not linger
   end
   always @(negedge RESET_N) busy = 1'b0;
endmodule
